// ### common/tla_pkg.sv
// shared constants, types and structs for the lookaside buffer access block
package tla_pkg;

	// ------------------------------------------------------------
	// alternate space codes, one set per translation unit
	// ------------------------------------------------------------
	localparam logic [7:0] ASI_TAG_STAGE_INSTR = 8'h50;
	localparam logic [7:0] ASI_TAG_STAGE_DATA  = 8'h58;
	localparam logic [7:0] ASI_DATA_IN_INSTR   = 8'h54;
	localparam logic [7:0] ASI_DATA_IN_DATA    = 8'h5c;
	localparam logic [7:0] ASI_DATA_ACC_INSTR  = 8'h55;
	localparam logic [7:0] ASI_DATA_ACC_DATA   = 8'h5d;

	// ------------------------------------------------------------
	// virtual addresses inside the spaces
	// ------------------------------------------------------------
	localparam logic [63:0] VA_TAG_STAGE_LOWER = 64'h0000_0000_0000_0030;
	localparam logic [63:0] VA_TAG_STAGE_UPPER = 64'h0000_0000_0008_0030;
	localparam logic [63:0] VA_DATA_IN         = 64'h0000_0000_0000_0000;

	// data access address fields
	localparam int DACC_BANK_MSB  = 18;
	localparam int DACC_BANK_LSB  = 16;
	localparam int DACC_WAY_MSB   = 15;
	localparam int DACC_WAY_LSB   = 11;
	localparam int DACC_IDX_MSB   = 9;
	localparam int DACC_IDX_LSB   = 3;
	localparam int DACC_IDX_W     = 7;
	localparam int MAX_ENTRIES    = 128;

	// ------------------------------------------------------------
	// staging register layout
	// ------------------------------------------------------------
	localparam int UP_REAL_BIT    = 63;
	localparam int UP_CTX_W       = 16;
	localparam int LO_PAGE_LSB    = 13;
	localparam int PAGE_W         = 51;
	localparam logic [15:0] CTX_RESET  = 16'h0000;
	localparam logic [50:0] PAGE_RESET = 51'h0;

	// page size field of the translation entry and legal codes
	localparam int TE_SIZE_LSB    = 0;
	localparam int TE_SIZE_W      = 4;
	localparam int SIZE_SHIFT_MUL = 3;
	localparam logic [15:0] SIZE_LEGAL_MASK = 16'h002b;

	// ------------------------------------------------------------
	// enums and carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		UNIT_INSTR   = 2'b00,
		UNIT_DATA    = 2'b01,
		UNIT_UNIFIED = 2'b10
	} tla_unit_type;

	typedef enum logic [1:0] {
		CTX_PRIMARY   = 2'b00,
		CTX_SECONDARY = 2'b01,
		CTX_KERNEL    = 2'b10,
		CTX_NONE      = 2'b11
	} tla_ctx_kind_type;

	typedef enum logic [1:0] {
		FAULT_NONE      = 2'b00,
		FAULT_BAD_SPACE = 2'b01,
		FAULT_PAGE_SIZE = 2'b10
	} tla_fault_type;

	typedef struct packed {
		logic        valid;
		logic        store;
		logic [7:0]  asi;
		logic [63:0] va;
		logic [63:0] wdata;
	} tla_req_type;

	typedef struct packed {
		logic          valid;
		tla_fault_type fault;
		logic [63:0]   rdata;
	} tla_rsp_type;

	typedef struct packed {
		logic             valid;
		tla_ctx_kind_type kind;
		logic [63:0]      va;
	} tla_miss_type;

	typedef struct packed {
		logic        valid;
		logic        real_map;
		logic [15:0] ctx;
		logic [63:0] va;
		logic [63:0] data;
	} tla_walk_type;

	typedef struct packed {
		logic        real_map;
		logic [7:0]  pid;
		logic [15:0] ctx;
		logic [50:0] page;
	} tla_tag_type;

endpackage

// ### dv/tla_access_top_tb.sv
// self-checking testbench of the staging and entry access registers
`timescale 1ns/1ps
`default_nettype none
module tla_access_top_tb import tla_pkg::*;;
	logic         ref_clk_in = 1'b0;
	logic         reset_in   = 1'b1;
	tla_req_type  req;
	tla_rsp_type  rsp;
	tla_req_type  req_i;
	tla_rsp_type  rsp_i;
	tla_miss_type miss_in    = '0;
	tla_walk_type walk_in    = '0;
	logic [15:0]  pri        = 16'h1111;
	logic [15:0]  sec        = 16'h2222;
	logic [15:0]  ker        = 16'h3333;
	logic [7:0]   pid        = 8'h5a;
	logic [63:0]  up;
	logic [63:0]  lo;
	logic [63:0]  up_i;
	logic [63:0]  lo_i;
	logic [15:0]  ctx_tab [4];
	logic [63:0]  last;
	int           miscompares = 0;
	int           checked     = 0;

	always #2.5 ref_clk_in = ~ref_clk_in;

	tla_access_top #(.UNIT(UNIT_DATA), .ENTRIES(64), .IDX_W(6)) uut (
		.ref_clk_in            (ref_clk_in),
		.reset_in              (reset_in),
		.req_in                (req),
		.rsp_out               (rsp),
		.miss_in               (miss_in),
		.primary_space_tag_in  (pri),
		.secondary_space_tag_in(sec),
		.kernel_space_tag_in   (ker),
		.walk_in               (walk_in),
		.partition_id_in       (pid),
		.upper_tag_staging_out (up),
		.lower_tag_staging_out (lo)
	);

	tla_core_model core (
		.ref_clk_in(ref_clk_in),
		.rsp_in    (rsp),
		.req_out   (req)
	);

	// instruction unit instance, shares the trap and walker events
	tla_access_top #(.UNIT(UNIT_INSTR), .ENTRIES(64), .IDX_W(6)) uut_i (
		.ref_clk_in            (ref_clk_in),
		.reset_in              (reset_in),
		.req_in                (req_i),
		.rsp_out               (rsp_i),
		.miss_in               (miss_in),
		.primary_space_tag_in  (pri),
		.secondary_space_tag_in(sec),
		.kernel_space_tag_in   (ker),
		.walk_in               (walk_in),
		.partition_id_in       (pid),
		.upper_tag_staging_out (up_i),
		.lower_tag_staging_out (lo_i)
	);

	tla_core_model core_i (
		.ref_clk_in(ref_clk_in),
		.rsp_in    (rsp_i),
		.req_out   (req_i)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic acc(input logic st, input logic [7:0] asi, input logic [63:0] va,
		input logic [63:0] wd, input tla_fault_type ef, input logic [63:0] ed);
		tla_rsp_type r;
		logic        late;
		core.access(st, asi, va, wd, r, late);
		if (late) begin
			miscompares++;
			final_report();
		end
		chk("fault", 64'(ef), 64'(r.fault));
		chk("rdata", ed, r.rdata);
	endtask

	task automatic acc_i(input logic st, input logic [7:0] asi, input logic [63:0] va,
		input logic [63:0] wd, input tla_fault_type ef, input logic [63:0] ed);
		tla_rsp_type r;
		logic        late;
		core_i.access(st, asi, va, wd, r, late);
		if (late) begin
			miscompares++;
			final_report();
		end
		chk("fault i", 64'(ef), 64'(r.fault));
		chk("rdata i", ed, r.rdata);
	endtask

	// side events stand for one edge; staging is looked at just after it
	task automatic inject(input tla_miss_type m, input tla_walk_type w);
		@(posedge ref_clk_in);
		miss_in <= m;
		walk_in <= w;
		@(posedge ref_clk_in);
		miss_in <= '0;
		walk_in <= '0;
		#1;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		static logic [7:0]  asis [8] = '{8'h5c, 8'h5c, 8'h50, 8'h54, 8'h55, 8'h5d, 8'h5d, 8'h5d};
		static logic [63:0] vas  [8] = '{64'h0, 64'h8, 64'h30, 64'h0, 64'h0, 64'h1_0000, 64'h800,
			64'h200};
		static logic        sts  [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		ctx_tab = '{pri, sec, ker, 16'h0};
		repeat (3) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		#1;
		chk("upper reset", 64'h0, up);
		chk("lower reset", 64'h0, lo);

		// reserved bits are dropped, change seen on the very next cycle
		acc(1, 8'h58, VA_TAG_STAGE_UPPER, 64'hffff_ffff_ffff_abcd, FAULT_NONE, 0);
		chk("upper", {1'b1, 47'h0, 16'habcd}, up);
		acc(1, 8'h58, 64'h30, 64'h00ab_cdef_1234_5fff, FAULT_NONE, 0);
		chk("lower", 64'h00ab_cdef_1234_4000, lo);
		acc(0, 8'h58, 64'h30, 0, FAULT_NONE, 64'h00ab_cdef_1234_4000);
		acc(0, 8'h58, VA_TAG_STAGE_UPPER, 0, FAULT_NONE, {1'b1, 47'h0, 16'habcd});

		// instruction unit: own spaces only, data unit spaces refused
		acc_i(1, ASI_TAG_STAGE_INSTR, 64'h30, 64'h1234_5678_9abc_ffff, FAULT_NONE, 0);
		chk("lower i", 64'h1234_5678_9abc_e000, lo_i);
		chk("lower d kept", 64'h00ab_cdef_1234_4000, lo);
		acc_i(1, ASI_DATA_IN_INSTR, 64'h0, 64'h8000_0000_0ace_0001, FAULT_NONE, 0);
		acc_i(0, ASI_DATA_ACC_INSTR, 64'h0, 0, FAULT_NONE, 64'h8000_0000_0ace_0001);
		acc_i(1, ASI_TAG_STAGE_DATA, 64'h30, 64'h0, FAULT_BAD_SPACE, 0);
		acc_i(0, ASI_DATA_IN_INSTR, 64'h0, 0, FAULT_BAD_SPACE, 0);
		chk("lower i kept", 64'h1234_5678_9abc_e000, lo_i);

		// refused accesses change nothing
		for (int i = 0; i < 8; i++) begin
			acc(sts[i], asis[i], vas[i], 64'hffff_ffff_ffff_fff0, FAULT_BAD_SPACE, 0);
		end
		chk("lower kept", 64'h00ab_cdef_1234_4000, lo);
		chk("upper kept", {1'b1, 47'h0, 16'habcd}, up);

		// replacement writes go to pointer 0 then 1
		acc(1, ASI_DATA_IN_DATA, 64'h0, 64'h8000_0000_1234_2000, FAULT_NONE, 0);
		acc(1, ASI_DATA_IN_DATA, 64'h0, 64'h8000_0000_5678_2001, FAULT_NONE, 0);
		acc(1, ASI_DATA_IN_DATA, 64'h0, 64'h8000_0000_1234_2002, FAULT_PAGE_SIZE, 0);
		acc(0, 8'h5d, 64'h0, 0, FAULT_NONE, 64'h8000_0000_1234_2000);
		acc(0, 8'h5d, 64'h8, 0, FAULT_NONE, 64'h8000_0000_5678_2001);

		// directed write after staging, then every size code
		acc(1, 8'h5d, 64'h28, 64'h8000_00ab_0000_0003, FAULT_NONE, 0);
		acc(0, 8'h5d, 64'h28, 0, FAULT_NONE, 64'h8000_00ab_0000_0003);
		last = 64'h0;
		for (int i = 0; i < 16; i++) begin
			if (SIZE_LEGAL_MASK[i])
				last = 64'h8000_0000_00c0_0000 | 64'(i);
			acc(1, 8'h5d, 64'h38, 64'h8000_0000_00c0_0000 | 64'(i),
				SIZE_LEGAL_MASK[i] ? FAULT_NONE : FAULT_PAGE_SIZE, 0);
		end
		acc(0, 8'h5d, 64'h38, 0, FAULT_NONE, last);

		// trap capture per context kind, real flag cleared
		for (int k = 0; k < 4; k++) begin
			inject('{valid: 1'b1, kind: tla_ctx_kind_type'(k), va: 64'hfedc_ba98_7654_3fff}, '0);
			chk("miss upper", {1'b0, 47'h0, ctx_tab[k]}, up);
			chk("miss lower", 64'hfedc_ba98_7654_2000, lo);
		end

		// walker fill loads staging
		inject('0, '{valid: 1'b1, real_map: 1'b1, ctx: 16'h0abc, va: 64'h00aa_bbcc_dd00_1fff,
			data: 64'h8000_0000_0bad_0000});
		chk("walk upper", {1'b1, 47'h0, 16'h0abc}, up);
		chk("walk lower", 64'h00aa_bbcc_dd00_0000, lo);
		final_report();
	end
endmodule
`default_nettype wire

// ### dv/tla_core_model.sv
// core-side model issuing alternate-space loads and stores
`timescale 1ns/1ps
`default_nettype none
module tla_core_model import tla_pkg::*; (
	input  wire logic        ref_clk_in, // core clock
	input  wire tla_rsp_type rsp_in,     // answer from block
	output tla_req_type      req_out     // alternate-space access
);
	initial req_out = '0;

	// ------------------------------------------------------------
	// one access: request stands for its taking edge only
	// ------------------------------------------------------------
	task automatic access(input logic st, input logic [7:0] asi, input logic [63:0] va,
		input logic [63:0] wd, output tla_rsp_type rsp, output logic late);
		int n;
		@(posedge ref_clk_in);
		req_out <= '{valid: 1'b1, store: st, asi: asi, va: va, wdata: wd};
		@(posedge ref_clk_in);
		// released lines show junk, so a stale value cannot pass
		req_out <= '{valid: 1'b0, store: ~st, asi: ~asi, va: ~va, wdata: ~wd};
		late = 1'b1;
		rsp = '0;
		// answer stands for one cycle only, so it is looked at mid-cycle
		for (n = 0; n < 4 && late; n++) begin
			@(negedge ref_clk_in);
			if (rsp_in.valid === 1'b1) begin
				rsp = rsp_in;
				late = 1'b0;
			end
		end
	endtask
endmodule
`default_nettype wire

// ### src/tla_access_top.sv
// tag staging, data input and data access registers of one translation unit
`timescale 1ns/1ps
`default_nettype none
module tla_access_top import tla_pkg::*; #(
	parameter tla_unit_type UNIT    = UNIT_DATA,
	parameter int           ENTRIES = 64,
	parameter int           IDX_W   = 6
) (
	input  wire logic         ref_clk_in,             // core clock, 200 MHz
	input  wire logic         reset_in,               // sync reset, high
	input  wire tla_req_type  req_in,                 // alternate-space access
	output tla_rsp_type       rsp_out,                // answer, one cycle later
	input  wire tla_miss_type miss_in,                // trap capture request
	input  wire logic [15:0]  primary_space_tag_in,   // primary context
	input  wire logic [15:0]  secondary_space_tag_in, // secondary context
	input  wire logic [15:0]  kernel_space_tag_in,    // nucleus context
	input  wire tla_walk_type walk_in,                // table walker fill
	input  wire logic [7:0]   partition_id_in,        // partition register
	output logic [63:0]       upper_tag_staging_out,  // to target/pointer logic
	output logic [63:0]       lower_tag_staging_out   // to target/pointer logic
);

	// ------------------------------------------------------------
	// space decode
	// ------------------------------------------------------------
	function automatic logic unit_asi(input logic [7:0] asi, input logic [7:0] instr_code,
			input logic [7:0] data_code);
		unit_asi = (UNIT == UNIT_INSTR) ? (asi == instr_code) : (asi == data_code);
	endfunction

	function automatic logic size_legal(input logic [63:0] data);
		size_legal = SIZE_LEGAL_MASK[data[TE_SIZE_LSB +: TE_SIZE_W]];
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic              real_reg;
	logic              real_next;
	logic [15:0]       ctx_reg;
	logic [15:0]       ctx_next;
	logic [50:0]       page_reg;
	logic [50:0]       page_next;
	logic [IDX_W-1:0]  repl_reg;
	logic [IDX_W-1:0]  repl_next;
	tla_rsp_type       rsp_reg;
	tla_rsp_type       rsp_next;

	logic              hit_tag;
	logic              hit_din;
	logic              hit_dacc;
	logic [DACC_IDX_W-1:0] idx_field;
	logic              idx_excess;
	logic              sel_fault;
	tla_fault_type     fault;
	logic              arr_wr;
	logic [IDX_W-1:0]  arr_idx;
	tla_tag_type       arr_tag;
	logic [63:0]       arr_wdata;
	logic [63:0]       arr_rdata;
	tla_tag_type       staged_tag;

	assign hit_tag   = unit_asi(req_in.asi, ASI_TAG_STAGE_INSTR, ASI_TAG_STAGE_DATA);
	assign hit_din   = unit_asi(req_in.asi, ASI_DATA_IN_INSTR, ASI_DATA_IN_DATA);
	assign hit_dacc  = unit_asi(req_in.asi, ASI_DATA_ACC_INSTR, ASI_DATA_ACC_DATA);
	assign idx_field = req_in.va[DACC_IDX_MSB:DACC_IDX_LSB];
	// capacity check covers buffers smaller than the full index range
	assign idx_excess = (idx_field >> IDX_W) != '0;
	assign sel_fault  = (req_in.va[DACC_BANK_MSB:DACC_BANK_LSB] != '0)
		|| (req_in.va[DACC_WAY_MSB:DACC_WAY_LSB] != '0);

	// staging tag joined with partition forms the new entry tag
	assign staged_tag = '{real_map: real_reg, pid: partition_id_in,
		ctx: ctx_reg, page: page_reg};

	// ------------------------------------------------------------
	// fault classification
	// ------------------------------------------------------------
	always_comb begin
		fault = FAULT_NONE;
		if (req_in.valid) begin
			if (hit_tag) begin
				if (req_in.va != VA_TAG_STAGE_LOWER && req_in.va != VA_TAG_STAGE_UPPER) begin
					fault = FAULT_BAD_SPACE;
				end
			end else if (hit_din) begin
				if (!req_in.store || req_in.va != VA_DATA_IN) begin
					fault = FAULT_BAD_SPACE;
				end else if (!size_legal(req_in.wdata)) begin
					fault = FAULT_PAGE_SIZE;
				end
			end else if (hit_dacc) begin
				if (sel_fault || idx_excess) begin
					fault = FAULT_BAD_SPACE;
				end else if (req_in.store && !size_legal(req_in.wdata)) begin
					fault = FAULT_PAGE_SIZE;
				end
			end else begin
				fault = FAULT_BAD_SPACE;
			end
		end
	end

	// ------------------------------------------------------------
	// entry writes: core stores and walker fills
	// ------------------------------------------------------------
	always_comb begin
		arr_wr    = 1'b0;
		arr_idx   = repl_reg;
		arr_tag   = staged_tag;
		arr_wdata = req_in.wdata;
		repl_next = repl_reg;
		if (req_in.valid && req_in.store && fault == FAULT_NONE && (hit_din || hit_dacc)) begin
			arr_wr = 1'b1;
			if (hit_dacc) begin
				arr_idx = idx_field[IDX_W-1:0];
			end else begin
				repl_next = repl_reg + 1'b1;
			end
		end else if (walk_in.valid) begin
			arr_wr    = 1'b1;
			arr_tag   = '{real_map: walk_in.real_map, pid: partition_id_in,
				ctx: walk_in.ctx, page: walk_in.va[63:LO_PAGE_LSB]};
			arr_wdata = walk_in.data;
			repl_next = repl_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// tag staging registers
	// ------------------------------------------------------------
	// kept as two registers so the full 16-bit context fits
	always_comb begin
		real_next = real_reg;
		ctx_next  = ctx_reg;
		page_next = page_reg;
		if (miss_in.valid) begin
			page_next = miss_in.va[63:LO_PAGE_LSB];
			real_next = 1'b0;
			case (miss_in.kind)
				CTX_PRIMARY: begin
					ctx_next = primary_space_tag_in;
				end
				CTX_SECONDARY: begin
					ctx_next = secondary_space_tag_in;
				end
				CTX_KERNEL: begin
					ctx_next = kernel_space_tag_in;
				end
				default: begin
					ctx_next = CTX_RESET;
				end
			endcase
		end else if (walk_in.valid && !(req_in.valid && req_in.store && (hit_din || hit_dacc)
				&& fault == FAULT_NONE)) begin
			real_next = walk_in.real_map;
			ctx_next  = walk_in.ctx;
			page_next = walk_in.va[63:LO_PAGE_LSB];
		end else if (req_in.valid && req_in.store && hit_tag && fault == FAULT_NONE) begin
			if (req_in.va == VA_TAG_STAGE_UPPER) begin
				real_next = req_in.wdata[UP_REAL_BIT];
				ctx_next  = req_in.wdata[UP_CTX_W-1:0];
			end else begin
				page_next = req_in.wdata[63:LO_PAGE_LSB];
			end
		end
	end

	// ------------------------------------------------------------
	// answer to the core
	// ------------------------------------------------------------
	always_comb begin
		rsp_next       = '0;
		rsp_next.valid = req_in.valid;
		rsp_next.fault = fault;
		if (req_in.valid && !req_in.store && fault == FAULT_NONE) begin
			if (hit_dacc) begin
				rsp_next.rdata = arr_rdata;
			end else if (req_in.va == VA_TAG_STAGE_UPPER) begin
				rsp_next.rdata = upper_tag_staging_out;
			end else begin
				rsp_next.rdata = lower_tag_staging_out;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			real_reg <= 1'b0;
			ctx_reg  <= CTX_RESET;
			page_reg <= PAGE_RESET;
			repl_reg <= '0;
			rsp_reg  <= '0;
		end else begin
			real_reg <= real_next;
			ctx_reg  <= ctx_next;
			page_reg <= page_next;
			repl_reg <= repl_next;
			rsp_reg  <= rsp_next;
		end
	end

	// straight from the flops, no extra stage for the pointer logic
	assign upper_tag_staging_out = {real_reg, 47'h0, ctx_reg};
	assign lower_tag_staging_out = {page_reg, 13'h0};
	assign rsp_out = rsp_reg;

	tla_entry_array #(
		.ENTRIES (ENTRIES),
		.IDX_W   (IDX_W)
	) u_array (
		.ref_clk_in  (ref_clk_in),
		.reset_in    (reset_in),
		.wr_en_in    (arr_wr),
		.wr_idx_in   (arr_idx),
		.wr_tag_in   (arr_tag),
		.wr_data_in  (arr_wdata),
		.rd_idx_in   (idx_field[IDX_W-1:0]),
		.rd_data_out (arr_rdata)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_stage_upper_store: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(req_in.valid && req_in.store && hit_tag && req_in.va == VA_TAG_STAGE_UPPER
		&& !miss_in.valid && !walk_in.valid)
		|=> upper_tag_staging_out[15:0] == $past(req_in.wdata[15:0])
		&& upper_tag_staging_out[63] == $past(req_in.wdata[63]))
		else $error("upper staging not written by store");

	a_stage_lower_visible: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(req_in.valid && req_in.store && hit_tag && req_in.va == VA_TAG_STAGE_LOWER
		&& !miss_in.valid && !walk_in.valid)
		|=> lower_tag_staging_out[63:13] == $past(req_in.wdata[63:13]))
		else $error("lower staging not visible next cycle");

	a_miss_capture: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(miss_in.valid && miss_in.kind == CTX_SECONDARY)
		|=> lower_tag_staging_out[63:13] == $past(miss_in.va[63:13])
		&& upper_tag_staging_out[15:0] == $past(secondary_space_tag_in))
		else $error("trap capture wrong page or context");

	a_none_ctx_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(miss_in.valid && miss_in.kind == CTX_NONE) |=> upper_tag_staging_out[15:0] == 16'h0000)
		else $error("context not zero without associated context");

	a_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		upper_tag_staging_out[62:16] == '0 && lower_tag_staging_out[12:0] == '0)
		else $error("reserved staging bits not zero");

	a_din_load_fault: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(req_in.valid && !req_in.store && hit_din)
		|=> rsp_out.valid && rsp_out.fault == FAULT_BAD_SPACE)
		else $error("data input load did not fault");

	a_bank_fault: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(req_in.valid && hit_dacc && req_in.va[18:16] != 3'h0 && !walk_in.valid)
		|-> !arr_wr ##1 rsp_out.fault == FAULT_BAD_SPACE)
		else $error("nonzero bank not refused");

	a_size_fault: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(req_in.valid && req_in.store && hit_din && req_in.va == VA_DATA_IN
		&& !size_legal(req_in.wdata) && !walk_in.valid)
		|-> !arr_wr ##1 rsp_out.fault == FAULT_PAGE_SIZE)
		else $error("reserved page size was written");

	a_fault_stable: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(req_in.valid && fault != FAULT_NONE && !miss_in.valid && !walk_in.valid)
		|=> $stable(upper_tag_staging_out) && $stable(lower_tag_staging_out))
		else $error("faulting access changed staging");

	a_din_write_tag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(req_in.valid && req_in.store && hit_din && fault == FAULT_NONE)
		|-> arr_wr && arr_tag.page == page_reg && arr_tag.pid == partition_id_in
		&& arr_idx == repl_reg ##1 repl_reg == $past(repl_reg) + 1'b1)
		else $error("data input write tag or pointer wrong");

endmodule
`default_nettype wire

// ### src/tla_entry_array.sv
// tag and data arrays of the lookaside buffer with duplicate removal on write
`timescale 1ns/1ps
`default_nettype none
module tla_entry_array import tla_pkg::*; #(
	parameter int ENTRIES = 64,
	parameter int IDX_W   = 6
) (
	input  wire logic             ref_clk_in,  // core clock
	input  wire logic             reset_in,    // sync reset, high
	input  wire logic             wr_en_in,    // write one entry
	input  wire logic [IDX_W-1:0] wr_idx_in,   // entry to write
	input  wire tla_tag_type      wr_tag_in,   // new tag
	input  wire logic [63:0]      wr_data_in,  // new entry data
	input  wire logic [IDX_W-1:0] rd_idx_in,   // entry to read
	output logic [63:0]           rd_data_out  // data of read entry
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [ENTRIES-1:0] used_reg;
	logic [ENTRIES-1:0] used_next;
	logic [ENTRIES-1:0] demap_hit;
	tla_tag_type        tag_reg  [ENTRIES];
	tla_tag_type        tag_next [ENTRIES];
	logic [63:0]        data_reg [ENTRIES];
	logic [63:0]        data_next[ENTRIES];

	function automatic logic [50:0] page_mask(input logic [TE_SIZE_W-1:0] sz);
		page_mask = {PAGE_W{1'b1}} << (SIZE_SHIFT_MUL * int'(sz));
	endfunction

	// ------------------------------------------------------------
	// duplicate and larger-overlap detection
	// ------------------------------------------------------------
	// comparing under the coarser of the two sizes also drops smaller
	// overlapped pages, which is allowed and avoids later multi-hits
	for (genvar i = 0; i < ENTRIES; i++) begin : g_demap
		logic [TE_SIZE_W-1:0] old_sz;
		logic [TE_SIZE_W-1:0] new_sz;
		logic [50:0]          mask;
		assign old_sz = data_reg[i][TE_SIZE_LSB +: TE_SIZE_W];
		assign new_sz = wr_data_in[TE_SIZE_LSB +: TE_SIZE_W];
		assign mask   = (old_sz > new_sz) ? page_mask(old_sz) : page_mask(new_sz);
		assign demap_hit[i] = used_reg[i]
			&& tag_reg[i].pid == wr_tag_in.pid
			&& tag_reg[i].real_map == wr_tag_in.real_map
			&& (wr_tag_in.real_map || tag_reg[i].ctx == wr_tag_in.ctx)
			&& ((tag_reg[i].page & mask) == (wr_tag_in.page & mask));
	end

	always_comb begin
		used_next = used_reg;
		tag_next  = tag_reg;
		data_next = data_reg;
		if (wr_en_in) begin
			used_next            = used_reg & ~demap_hit;
			used_next[wr_idx_in] = 1'b1;
			tag_next[wr_idx_in]  = wr_tag_in;
			data_next[wr_idx_in] = wr_data_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			used_reg <= '0;
		end else begin
			used_reg <= used_next;
		end
		tag_reg  <= tag_next;
		data_reg <= data_next;
	end

	assign rd_data_out = data_reg[rd_idx_in];

endmodule
`default_nettype wire
